/* File: rtl/asrs_pkg.sv */
// Constants, types and helpers shared by the sleep rail sequencer
// Notes on behaviour
// R1: Soft-start is held off until the power-on reset has been extended 3.3ms past the standby supply threshold, in any requested state.
// R2: The memory level selection is captured at every standby power-on trip and held until the next one.
// R3: Both sleep inputs high decode as active, only suspend low as suspend-to-RAM, both low as soft-off.
// R4: The aux rail is on in active and suspend, and in soft-off only while the active-low aux keep enable is 0.
// R5: The dual 5V rail is on in active, and in both sleep states only while the dual5 keep enable is 1.
// R6: The memory rail is on at the captured level in active and suspend, and off in soft-off.
// R7: Soft-off low with suspend high is an illegal pair; the state keeps its value and the invalid event is flagged; leaving POR on it enters soft-off.
// R8: A direct move between the two sleep states is refused; only active to sleep and back are taken.
// R9: Keep enable changes are ignored in sleep and followed in active, below reset level and in shutdown.
// R10: A change of the suspend input starts a 200us deglitch timer, and the state moves at expiry only on a valid request.
// R11: In a sleep state with the dual 5V rail kept, the standby switch drive is asserted.
// R12: The dual 5V rail sense is watched for undervoltage and feeds the common fault output.
// R13: On the way into soft-off the system may lower suspend up to 200us before soft-off.
// R14: The keep enables are latched on sleep entry, after reset release and on shutdown exit.
// R15: On power-up into active all switches stay off until 50ms after the 12V monitor reports good.
// R16: Pin inputs pass two-stage synchronisers and intervals are counted on the system clock.
// R17: While power-on reset is active the rail enables are off and the state is at its reset value.
package asrs_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam real         CLK_PERIOD_NS = 100.0;
  localparam real         POR_EXT_MS    = 3.3;
  localparam real         DEGLITCH_US   = 200.0;
  localparam real         V12_WAIT_MS   = 50.0;
  localparam int unsigned POR_EXT_CYC   =
    int'($ceil(POR_EXT_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int unsigned DEGLITCH_CYC  =
    int'($ceil(DEGLITCH_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int unsigned V12_WAIT_CYC  =
    int'($ceil(V12_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
  localparam int          TIMER_W       = 20;

  // ************************************************************
  // Register port
  // ************************************************************
  localparam int              ADDR_W       = 4;
  localparam int              DATA_W       = 8;
  localparam logic [ADDR_W-1:0] REG_STATE    = 4'h0;
  localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 4'h8;
  // Event bits of status and mask
  localparam int              EV_STATE     = 0;
  localparam int              EV_REFUSE    = 1;
  localparam int              EV_INVALID   = 2;
  localparam int              EV_FAULT     = 3;
  localparam int              EV_W         = 4;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
  // State register: [4:0] state, [5] aux keep, [6] dual5 keep, [7] level
  localparam int              PIN_W        = 10;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [4:0] {
    ST_POR     = 5'h01,
    ST_WAIT12  = 5'h02,
    ST_ACTIVE  = 5'h04,
    ST_SUSPEND = 5'h08,
    ST_SOFTOFF = 5'h10
  } asrs_state_t;

  typedef enum logic [1:0] {
    REQ_SOFTOFF = 2'h0,
    REQ_INVALID = 2'h1,
    REQ_SUSPEND = 2'h2,
    REQ_ACTIVE  = 2'h3
  } asrs_req_t;

  // Decodes {soft_off_req_n, suspend_ram_req_n}
  function automatic asrs_req_t req_decode(input logic suspend_ram_req_n,
                                           input logic soft_off_req_n);
    return asrs_req_t'({soft_off_req_n, suspend_ram_req_n});
  endfunction

endpackage

/* File: rtl/asrs_sync.sv */
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
module asrs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] stage1;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule

/* File: rtl/asrs_timer.sv */
// Restartable one-shot interval timer
`timescale 1ns/10ps
module asrs_timer
  import asrs_pkg::*;
#(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      done_o
);
  logic [TIMER_W-1:0] cnt;
  logic               busy;
  wire                at_end = busy && (cnt == '0);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt    <= '0;
      busy   <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= at_end && !start_i;
      if (start_i) begin
        cnt  <= TIMER_W'(CYCLES - 1);
        busy <= 1'b1;
      end else if (at_end) begin
        busy <= 1'b0;
      end else if (busy) begin
        cnt <= cnt - 1'b1;
      end
    end
  end
endmodule

/* File: rtl/asrs_top.sv */
// Sleep state decoder and rail sequencer with register port
`timescale 1ns/10ps
module asrs_top
  import asrs_pkg::*;
#(
  parameter int unsigned POR_EXT_CYCLES  = POR_EXT_CYC,
  parameter int unsigned V12_WAIT_CYCLES = V12_WAIT_CYC
) (
  input  wire logic              SYS_CLK_I,
  input  wire logic              RST_I,
  input  wire logic              STBY_OK_I,
  input  wire logic              V12_OK_I,
  input  wire logic              SUSPEND_RAM_REQ_N_I,
  input  wire logic              SOFT_OFF_REQ_N_I,
  input  wire logic              AUX33_KEEP_EN_N_I,
  input  wire logic              DUAL5_KEEP_EN_N_I,
  input  wire logic              MEM_LEVEL_SELECT_I,
  input  wire logic              SHUTDOWN_I,
  input  wire logic              DUAL5_RAIL_SENSE_I,
  input  wire logic              AUX33_RAIL_SENSE_I,
  input  wire logic [ADDR_W-1:0] ADDR_I,
  input  wire logic [DATA_W-1:0] WR_DATA_I,
  input  wire logic              WR_I,
  input  wire logic              RD_I,
  output logic      [DATA_W-1:0] RD_DATA_O,
  output logic                   AUX33_EN_O,
  output logic                   DUAL5_EN_O,
  output logic                   MEM_EN_O,
  output logic                   MEM_LEVEL_33_O,
  output logic                   ACTIVE_SWITCH_DRIVE_O,
  output logic                   DUAL5_STANDBY_DRIVE_O,
  output logic                   SOFTSTART_EN_O,
  output logic                   FAULT_O,
  output logic                   IRQ_O
);

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [PIN_W-1:0] pins;

  asrs_sync #(.W(PIN_W)) u_sync ( // R16
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .async_i ({AUX33_RAIL_SENSE_I, DUAL5_RAIL_SENSE_I, SHUTDOWN_I,
               MEM_LEVEL_SELECT_I, DUAL5_KEEP_EN_N_I, AUX33_KEEP_EN_N_I,
               SOFT_OFF_REQ_N_I, SUSPEND_RAM_REQ_N_I, V12_OK_I,
               STBY_OK_I}),
    .sync_o  (pins)
  );

  wire stby_ok           = pins[0];
  wire v12_ok            = pins[1];
  wire suspend_ram_req_n = pins[2];
  wire soft_off_req_n    = pins[3];
  wire aux33_keep_in_n   = pins[4];
  wire dual5_keep_in_n   = pins[5];
  wire mem_sel_in        = pins[6];
  wire shutdown          = pins[7];
  wire dual5_ok          = pins[8];
  wire aux33_ok          = pins[9];

  // ************************************************************
  // Power-on reset extension and level capture
  // ************************************************************
  asrs_state_t       state;
  asrs_state_t       next_state;
  logic              stby_prev;
  logic              por_released;
  logic              por_done;
  logic              mem_level;
  logic              susp_prev;
  logic              dg_done;
  logic              v12_armed;
  logic              wait_done_raw;
  logic              aux33_keep_en_n;
  logic              dual5_keep_en_n;
  logic [EV_W-1:0]   irq_stat;
  logic [EV_W-1:0]   irq_mask;

  wire por_start   = stby_ok && !stby_prev;
  wire por_capture = por_done && stby_ok;

  asrs_timer #(.CYCLES(POR_EXT_CYCLES)) u_por_timer ( // R16
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .start_i (por_start),
    .done_o  (por_done)
  );

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      stby_prev    <= 1'b0;
      por_released <= 1'b0;
      mem_level    <= 1'b0;
    end else begin
      stby_prev <= stby_ok;
      if (!stby_ok) begin
        por_released <= 1'b0;
      end else if (por_done) begin
        por_released <= 1'b1; // R1
      end
      if (por_capture) begin
        mem_level <= mem_sel_in; // R2
      end
    end
  end

  // ************************************************************
  // Request decode and deglitch
  // ************************************************************
  wire asrs_req_t req = req_decode(suspend_ram_req_n, soft_off_req_n); // R3
  wire susp_edge = (suspend_ram_req_n != susp_prev) && por_released;
  wire req_sleep = (req == REQ_SUSPEND) || (req == REQ_SOFTOFF);

  asrs_timer #(.CYCLES(DEGLITCH_CYC)) u_dg_timer ( // R10 R13 R16
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .start_i (susp_edge),
    .done_o  (dg_done)
  );

  // ************************************************************
  // 12V settle wait
  // ************************************************************
  wire in_wait   = (state == ST_WAIT12);
  wire w_start   = in_wait && v12_ok && !v12_armed;
  wire wait_done = wait_done_raw && in_wait && v12_ok && v12_armed;

  asrs_timer #(.CYCLES(V12_WAIT_CYCLES)) u_v12_timer ( // R15 R16
    .clk_i   (SYS_CLK_I),
    .rst_i   (RST_I),
    .start_i (w_start),
    .done_o  (wait_done_raw)
  );

  // ************************************************************
  // State machine
  // ************************************************************
  logic ev_refuse;

  always_comb begin
    next_state = state;
    ev_refuse  = 1'b0;
    case (state)
      ST_POR: begin
        if (por_released) begin
          case (req)
            REQ_ACTIVE:  next_state = ST_WAIT12;
            REQ_SUSPEND: next_state = ST_SUSPEND;
            default:     next_state = ST_SOFTOFF;
          endcase
        end
      end
      ST_WAIT12, ST_ACTIVE: begin
        if (dg_done && req_sleep) begin // R10
          next_state = (req == REQ_SUSPEND) ? ST_SUSPEND : ST_SOFTOFF;
        end else if (wait_done) begin
          next_state = ST_ACTIVE; // R15
        end
      end
      ST_SUSPEND: begin
        if (dg_done && (req == REQ_ACTIVE)) begin
          next_state = ST_ACTIVE;
        end else if (dg_done && (req == REQ_SOFTOFF)) begin
          ev_refuse = 1'b1; // R8
        end
      end
      ST_SOFTOFF: begin
        if (dg_done && (req == REQ_ACTIVE)) begin
          next_state = ST_ACTIVE;
        end else if (dg_done && (req == REQ_SUSPEND)) begin
          ev_refuse = 1'b1; // R8
        end
      end
      default: next_state = ST_POR;
    endcase
    if (!por_released) begin
      next_state = ST_POR; // R17
    end
  end

  // ************************************************************
  // Keep enables
  // ************************************************************
  wire in_active = (state == ST_ACTIVE);
  wire in_susp   = (state == ST_SUSPEND);
  wire in_off    = (state == ST_SOFTOFF);
  wire in_sleep  = in_susp || in_off;
  wire keep_upd  = !in_sleep || shutdown; // R9 R14

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state           <= ST_POR;
      susp_prev       <= 1'b1;
      v12_armed       <= 1'b0;
      aux33_keep_en_n <= 1'b1;
      dual5_keep_en_n <= 1'b0;
    end else begin
      state     <= next_state;
      susp_prev <= suspend_ram_req_n;
      v12_armed <= in_wait && v12_ok;
      if (keep_upd) begin
        aux33_keep_en_n <= aux33_keep_in_n; // R9 R14
        dual5_keep_en_n <= dual5_keep_in_n; // R9 R14
      end
    end
  end

  // ************************************************************
  // Rail outputs
  // ************************************************************
  wire run       = !shutdown;
  wire next_aux  = run && (in_active || in_susp ||
                           (in_off && !aux33_keep_en_n)); // R4
  wire next_d5   = run && (in_active || (in_sleep && dual5_keep_en_n)); // R5
  wire next_mem  = run && (in_active || in_susp); // R6
  wire next_asw  = run && in_active;
  wire next_sbd  = run && in_sleep && dual5_keep_en_n; // R11
  wire next_ss   = run && por_released; // R1
  wire next_fault = run && ((DUAL5_EN_O && !dual5_ok) ||
                            (AUX33_EN_O && !aux33_ok)); // R12

  // ************************************************************
  // Register port and interrupt
  // ************************************************************
  wire [EV_W-1:0] events;
  assign events[EV_STATE]   = (next_state != state);
  assign events[EV_REFUSE]  = ev_refuse;
  assign events[EV_INVALID] = dg_done && (req == REQ_INVALID); // R7
  assign events[EV_FAULT]   = next_fault && !FAULT_O;

  wire            wr_stat   = WR_I && (ADDR_I == REG_IRQ_STAT);
  wire            wr_mask   = WR_I && (ADDR_I == REG_IRQ_MASK);
  wire [EV_W-1:0] clr       = wr_stat ? WR_DATA_I[EV_W-1:0] : '0;
  wire [EV_W-1:0] next_stat = (irq_stat & ~clr) | events;
  wire [EV_W-1:0] next_mask = wr_mask ? WR_DATA_I[EV_W-1:0] : irq_mask;
  wire [DATA_W-1:0] ev_pad  = DATA_W'(irq_stat);
  wire [DATA_W-1:0] mk_pad  = DATA_W'(irq_mask);
  wire [DATA_W-1:0] st_word = {mem_level, dual5_keep_en_n,
                               aux33_keep_en_n, state};
  wire [DATA_W-1:0] rd_mux  =
    (ADDR_I == REG_STATE)    ? st_word :
    (ADDR_I == REG_IRQ_STAT) ? ev_pad  :
    (ADDR_I == REG_IRQ_MASK) ? mk_pad  : '0;

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      irq_stat              <= '0;
      irq_mask              <= IRQ_MASK_RST;
      IRQ_O                 <= 1'b0;
      RD_DATA_O             <= '0;
      AUX33_EN_O            <= 1'b0;
      DUAL5_EN_O            <= 1'b0;
      MEM_EN_O              <= 1'b0;
      MEM_LEVEL_33_O        <= 1'b0;
      ACTIVE_SWITCH_DRIVE_O <= 1'b0;
      DUAL5_STANDBY_DRIVE_O <= 1'b0;
      SOFTSTART_EN_O        <= 1'b0;
      FAULT_O               <= 1'b0;
    end else begin
      irq_stat              <= next_stat;
      irq_mask              <= next_mask;
      IRQ_O                 <= |(next_stat & next_mask);
      RD_DATA_O             <= RD_I ? rd_mux : '0;
      AUX33_EN_O            <= next_aux;
      DUAL5_EN_O            <= next_d5;
      MEM_EN_O              <= next_mem;
      MEM_LEVEL_33_O        <= mem_level; // R6
      ACTIVE_SWITCH_DRIVE_O <= next_asw;
      DUAL5_STANDBY_DRIVE_O <= next_sbd;
      SOFTSTART_EN_O        <= next_ss;
      FAULT_O               <= next_fault;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);

  por_softstart_a: assert property ( // R1
    !por_released |=> !SOFTSTART_EN_O
  ) else $error("Soft-start enabled before reset extension");

  mem_capture_a: assert property ( // R2
    por_capture |=> (mem_level == $past(mem_sel_in))
                    ##1 $stable(mem_level)
  ) else $error("Memory level not captured at reset trip");

  level_hold_a: assert property ( // R2
    !por_capture |=> $stable(mem_level)
  ) else $error("Memory level changed without a reset trip");

  decode_susp_a: assert property ( // R3
    (in_active && dg_done && (req == REQ_SUSPEND) && por_released)
      |=> (state == ST_SUSPEND) ##1 MEM_EN_O == !$past(shutdown)
  ) else $error("Suspend request not decoded");

  aux_rail_a: assert property ( // R4
    (in_off && !shutdown) |=> (AUX33_EN_O == !$past(aux33_keep_en_n))
  ) else $error("Aux rail wrong in soft-off");

  dual5_rail_a: assert property ( // R5
    (in_susp && !shutdown) |=> (DUAL5_EN_O == $past(dual5_keep_en_n))
  ) else $error("Dual 5V rail wrong in suspend");

  mem_off_a: assert property ( // R6
    in_off |=> !MEM_EN_O
  ) else $error("Memory rail on in soft-off");

  invalid_hold_a: assert property ( // R7
    (dg_done && (req == REQ_INVALID) && por_released && (state != ST_POR))
      |=> $stable(state)
  ) else $error("State moved on illegal input pair");

  no_swap_a: assert property ( // R8
    (in_susp && por_released) |=> (state != ST_SOFTOFF)
  ) else $error("Direct move from suspend to soft-off");

  keep_frozen_a: assert property ( // R9
    (in_sleep && !shutdown)
      |=> $stable(aux33_keep_en_n) && $stable(dual5_keep_en_n)
  ) else $error("Keep enable changed in sleep");

  dg_gate_a: assert property ( // R10
    (in_active && por_released && !dg_done) |=> !in_sleep
  ) else $error("Sleep entered without deglitch expiry");

  stby_drive_a: assert property ( // R11
    (in_sleep && dual5_keep_en_n && !shutdown)
      |=> DUAL5_STANDBY_DRIVE_O && !ACTIVE_SWITCH_DRIVE_O
  ) else $error("Standby drive missing in sleep");

  fault_a: assert property ( // R12
    (DUAL5_EN_O && !dual5_ok && !shutdown) |=> FAULT_O
  ) else $error("Dual 5V undervoltage not reported");

  wait_off_a: assert property ( // R15
    in_wait |=> !ACTIVE_SWITCH_DRIVE_O && !AUX33_EN_O && !DUAL5_EN_O
  ) else $error("Switch on before 12V settle wait");

  por_off_a: assert property ( // R17
    (state == ST_POR) |=> !AUX33_EN_O && !DUAL5_EN_O && !MEM_EN_O
  ) else $error("Rail enabled during power-on reset");

endmodule

/* File: bench/asrs_chipset_model.sv */
// Chipset side model that drives the two active-low sleep requests
`timescale 1ns/10ps
module asrs_chipset_model
  import asrs_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire asrs_req_t  target_i,
  input  wire logic [11:0] skew_i,
  output logic            suspend_ram_req_n_o,
  output logic            soft_off_req_n_o
);
  logic [11:0] cnt;
  logic        soft_next;

  // Pins idle high, as with the pull-ups to standby
  initial begin
    suspend_ram_req_n_o = 1'b1;
    soft_off_req_n_o    = 1'b1;
    cnt                 = 12'h000;
    soft_next           = 1'b1;
  end

  // Invalid pair when commanded, or while soft-off lags a skewed request to active
  always @(posedge clk_i) begin
    if (go_i) begin
      suspend_ram_req_n_o <= target_i[0];
      soft_next           <= target_i[1];
      cnt                 <= skew_i;
      if (skew_i == 12'h000) begin
        soft_off_req_n_o <= target_i[1];
      end
    end else if (cnt != 12'h000) begin
      cnt <= cnt - 12'h001;
      if (cnt == 12'h001) begin
        soft_off_req_n_o <= soft_next;
      end
    end
  end
endmodule

/* File: bench/asrs_tb_top.sv */
// Self-checking bench for the sleep rail sequencer
`timescale 1ns/10ps
module asrs_tb_top
  import asrs_pkg::*;
;
  logic              clk = 1'b0, rst = 1'b1, stby_ok = 1'b0, v12_ok = 1'b0;
  logic              aux_n = 1'b1, d5_n = 1'b0, lvl_sel = 1'b0, shdn = 1'b0;
  logic              d5_sense = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
  logic              chk = 1'b0, go = 1'b0, sus_n, soft_n, aux_sense = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata;
  asrs_req_t         tgt = REQ_ACTIVE;
  logic [11:0]       skew = 12'h000;
  logic              aux_o, d5_o, mem_o, lvl_o, act_o, sb_o, ss_o, flt_o, irq_o;
  logic [8:0]        outs;
  logic [15:0]       rq[$];
  logic [17:0]       oq[$];
  integer            seed = 32'h060f;
  int                bad_count = 0, tests_run = 0, cyc = 0;

  assign outs = {aux_o, d5_o, mem_o, lvl_o, act_o, sb_o, ss_o, flt_o, irq_o};

  always #50 clk = ~clk;

  asrs_chipset_model u_asrs_chipset_model (.clk_i(clk), .go_i(go),
    .target_i(tgt), .skew_i(skew), .suspend_ram_req_n_o(sus_n),
    .soft_off_req_n_o(soft_n));

  asrs_top #(.POR_EXT_CYCLES(20), .V12_WAIT_CYCLES(30)) u_asrs_top (
    .SYS_CLK_I(clk), .RST_I(rst), .STBY_OK_I(stby_ok), .V12_OK_I(v12_ok),
    .SUSPEND_RAM_REQ_N_I(sus_n), .SOFT_OFF_REQ_N_I(soft_n),
    .AUX33_KEEP_EN_N_I(aux_n), .DUAL5_KEEP_EN_N_I(d5_n),
    .MEM_LEVEL_SELECT_I(lvl_sel), .SHUTDOWN_I(shdn),
    .DUAL5_RAIL_SENSE_I(d5_sense), .AUX33_RAIL_SENSE_I(aux_sense),
    .ADDR_I(addr), .WR_DATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RD_DATA_O(rdata), .AUX33_EN_O(aux_o), .DUAL5_EN_O(d5_o),
    .MEM_EN_O(mem_o), .MEM_LEVEL_33_O(lvl_o), .ACTIVE_SWITCH_DRIVE_O(act_o),
    .DUAL5_STANDBY_DRIVE_O(sb_o), .SOFTSTART_EN_O(ss_o), .FAULT_O(flt_o),
    .IRQ_O(irq_o));

  // ************************************************************
  // Checking
  // ************************************************************
  task automatic conclude;
    if (bad_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic cmp_rd(input logic [15:0] n);
    tests_run++;
    if ((rdata & n[15:8]) !== n[7:0]) begin
      bad_count++;
      $display("MISMATCH %0t read %h expected %h", $time, rdata, n[7:0]);
    end
  endtask

  task automatic cmp_out(input logic [17:0] n);
    tests_run++;
    if ((outs & n[17:9]) !== n[8:0]) begin
      bad_count++;
      $display("MISMATCH %0t outputs %h expected %h", $time, outs, n[8:0]);
    end
  endtask

  // Watcher takes the oldest note whenever a result stands
  always @(posedge clk) begin
    cyc  <= cyc + 1;
    rd_d <= rd;
    if (rd_d) cmp_rd(rq.pop_front());
    if (chk) cmp_out(oq.pop_front());
    if (cyc == 90000) begin
      bad_count++;
      conclude();
    end
  end

  // ************************************************************
  // Drivers
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [7:0] e,
                        input logic [7:0] m);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    rq.push_back({m, e & m});
    @(posedge clk);
    rd   <= 1'b0;
  endtask

  task automatic check(input logic [8:0] m, input logic [8:0] e);
    @(posedge clk);
    chk <= 1'b1;
    oq.push_back({m, e & m});
    @(posedge clk);
    chk <= 1'b0;
  endtask

  task automatic req(input asrs_req_t t, input logic [11:0] k);
    @(posedge clk);
    tgt  <= t;
    skew <= k;
    go   <= 1'b1;
    @(posedge clk);
    go   <= 1'b0;
  endtask

  function automatic logic [8:0] exp_o(input logic [1:0] s, input logic a,
                                       input logic d, input logic l);
    return {(s != 2'h2) | ~a, (s == 2'h0) | d, s != 2'h2, l, s == 2'h0,
            (s != 2'h0) & d, 1'b1, 1'b0, 1'b0};
  endfunction

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial begin
    logic [1:0] s;
    logic       l, a, d;
    l       = 1'($random(seed));
    check(9'h1FF, 9'h000);
    lvl_sel <= l;
    tick(4);
    rst     <= 1'b0;
    stby_ok <= 1'b1;
    tick(12);
    check(9'h004, 9'h000);
    tick(40);
    check(9'h1DC, 9'h004);
    v12_ok <= 1'b1;
    for (int i = 0; i < 100 && act_o !== 1'b1; i++) @(posedge clk);
    tick(2);
    check(9'h1FF, exp_o(2'h0, 1'b1, 1'b0, l));
    rd_reg(REG_STATE, {l, 7'h04}, 8'h9F);
    for (int k = 0; k < 8; k++) begin
      a = k[0];
      d = k[1];
      s = k[2] ? 2'h2 : 2'h1;
      aux_n <= a;
      d5_n  <= d;
      tick(6);
      req(k[2] ? REQ_SOFTOFF : REQ_SUSPEND,
          k[2] ? 12'(100 + ($random(seed) & 1023)) : 12'h000);
      tick(2100);
      check(9'h1FF, exp_o(s, a, d, l));
      aux_n <= ~a;
      d5_n  <= ~d;
      tick(10);
      check(9'h1FF, exp_o(s, a, d, l));
      req(REQ_ACTIVE, 12'h000);
      tick(10);
      req(k[2] ? REQ_SUSPEND : REQ_SOFTOFF, 12'h000);
      tick(2100);
      check(9'h1FF, exp_o(s, a, d, l));
      req(REQ_ACTIVE, 12'h000);
      tick(2100);
      check(9'h1FF, exp_o(2'h0, ~a, ~d, l));
    end
    req(REQ_SUSPEND, 12'h000);
    tick(5);
    req(REQ_INVALID, 12'h000);
    tick(2100);
    check(9'h1FF, exp_o(2'h0, 1'b0, 1'b0, l));
    rd_reg(REG_IRQ_STAT, 8'h07, 8'h07);
    wr_reg(REG_IRQ_MASK, 8'h04);
    tick(3);
    check(9'h001, 9'h001);
    wr_reg(REG_IRQ_STAT, 8'h07);
    tick(3);
    check(9'h001, 9'h000);
    rd_reg(REG_IRQ_STAT, 8'h00, 8'h07);
    req(REQ_ACTIVE, 12'h000);
    wr_reg(REG_IRQ_MASK, 8'h08);
    d5_sense <= 1'b0;
    tick(6);
    check(9'h003, 9'h003);
    d5_sense <= 1'b1;
    tick(6);
    check(9'h003, 9'h001);
    aux_sense <= 1'b0;
    tick(6);
    check(9'h002, 9'h002);
    aux_sense <= 1'b1;
    rd_reg(4'h2, 8'h00, 8'hFF);
    wr_reg(4'hC, 8'hFF);
    rd_reg(REG_IRQ_MASK, 8'h08, 8'h0F);
    shdn <= 1'b1;
    tick(6);
    check(9'h1DE, 9'h000);
    shdn    <= 1'b0;
    lvl_sel <= ~l;
    tick(10);
    check(9'h020, exp_o(2'h0, 1'b0, 1'b0, l));
    stby_ok <= 1'b0;
    tick(8);
    check(9'h1DC, 9'h000);
    stby_ok <= 1'b1;
    l = ~l;
    tick(150);
    check(9'h1FE, exp_o(2'h0, 1'b0, 1'b0, l));
    conclude();
  end
endmodule
